// >>> vcf_checker.sv
// Port-level checks on the playback feed.
// Assumes one clock domain and synchronous active-low nrst.
`timescale 1ns/1ps
module vcf_checker import vcf_pkg::*; #(
    parameter int unsigned FIFO_DEPTH = 16
) (
    // Clock, reset, bus
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic [19:0] addr,
    input wire logic        io_mem,
    input wire logic        ale,
    input wire logic        phase2,
    // Decode and read
    input wire logic        io_decode_gate,
    input wire logic        codec_port_select_n,
    input wire logic        data_oe,
    // Codec and volume
    input wire logic        transmit_shift_clock,
    input wire logic        receive_shift_clock,
    input wire logic        codec_serial_input,
    input wire logic        data_terminal_ready_n,
    input wire logic        encode_decode_select,
    input wire logic        audio_pass_en,
    input wire logic        bias_pass_en
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_gate_open;
        $rose(io_decode_gate) ##1 io_decode_gate;
    endsequence
    sequence s_our_page;
        addr[19:5] == ADAPTER_ADDR[19:5] && !io_mem;
    endsequence

    a_reset_quiet: assert property (disable iff (1'b0)
        !nrst |=> codec_port_select_n && !io_decode_gate && !data_oe)
        else $error("outputs not cleared by reset");
    a_select_decode: assert property (s_our_page ##0 s_gate_open
        |-> ##[0:2] !codec_port_select_n) else $error("select missing");
    a_select_cause: assert property ($fell(codec_port_select_n)
        |-> $past(io_decode_gate) && addr[19:5] == ADAPTER_ADDR[19:5] && !io_mem)
        else $error("stray select");
    a_select_stands: assert property ($fell(codec_port_select_n)
        |=> !codec_port_select_n [*4]) else $error("select dropped early");
    a_gate_phase: assert property ($rose(io_decode_gate) |-> phase2 && !ale)
        else $error("gate rose outside phase2");
    a_oe_select: assert property ($rose(data_oe) |-> $past(!codec_port_select_n))
        else $error("bus driven without select");
    a_serial_edge: assert property ($changed(codec_serial_input)
        |-> ##[0:1] transmit_shift_clock) else $error("serial bit moved off clock");
    a_shift_pair: assert property (receive_shift_clock == transmit_shift_clock)
        else $error("shift clocks differ");
    a_decode_mode: assert property (encode_decode_select == !data_terminal_ready_n)
        else $error("mode not inverse of ready");
    a_bias_inverse: assert property (bias_pass_en == !audio_pass_en)
        else $error("switch halves overlap");
endmodule // vcf_checker

bind vcf_playback vcf_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_vcf_checker (
    .clock(clock), .nrst(nrst), .addr(addr), .io_mem(io_mem), .ale(ale),
    .phase2(phase2), .io_decode_gate(io_decode_gate),
    .codec_port_select_n(codec_port_select_n), .data_oe(data_oe),
    .transmit_shift_clock(transmit_shift_clock),
    .receive_shift_clock(receive_shift_clock),
    .codec_serial_input(codec_serial_input),
    .data_terminal_ready_n(data_terminal_ready_n),
    .encode_decode_select(encode_decode_select),
    .audio_pass_en(audio_pass_en), .bias_pass_en(bias_pass_en)
);

// >>> vcf_host_model.sv
// Host side: processor bus cycles, codec clock and volume pattern.
// Assumes the bench clock; pins move 1 ns after a rising edge.
`timescale 1ns/1ps
module vcf_host_model import vcf_pkg::*; (
    // Clock
    input  wire logic       clock,
    // Pins toward the feed
    output vcf_pins_s       pins,
    input  wire logic [7:0] rdata,
    // Controls from the bench
    input  wire logic [2:0] vol_level,
    input  wire logic       run_clk
);
    vcf_pins_s  b;
    logic       ck;
    logic       vol    = 1'b0;
    logic [5:0] tick_q = 6'h00;

    always_comb begin
        pins = b;
        pins.port_b_bit_seven = ck;
        pins.port_b_control_two = vol;
    end

    initial begin
        b = '0;
        b.io_mem = 1'b1;
        b.wr_n = 1'b1;
        b.rd_n = 1'b1;
    end

    // Codec clock stands high between frames
    initial begin
        ck = 1'b1;
        #38.5;
        forever #100 ck = run_clk ? ~ck : 1'b1;
    end

    // Eight slots per gating cycle; level 7 keeps the line high
    always @(posedge clock) begin
        tick_q <= tick_q + 6'h01;
        vol <= #1 (tick_q[5:3] <= vol_level);
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic cycle(input logic [19:0] a, input logic io, input logic sel,
                         input logic wr, input logic [7:0] d, output logic [7:0] q);
        b.addr = a;
        b.io_mem = io;
        b.register_select = sel;
        b.ale = 1'b1;
        wt(8);
        b.ale = 1'b0;
        wt(8);
        b.phase2 = 1'b1;
        wt(8);
        b.data = d;
        b.wr_n = ~wr;
        b.rd_n = wr;
        wt(4);
        b.enable_clock = 1'b1;
        repeat (20) @(posedge clock);
        q = rdata;
        #1;
        b.enable_clock = 1'b0;
        b.wr_n = 1'b1;
        b.rd_n = 1'b1;
        b.data = ~d;
        b.phase2 = 1'b0;
        wt(4);
    endtask
endmodule // vcf_host_model

// >>> vcf_pkg.sv
// Constants and carrier types for the voice codec playback feed.
// Assumes a single 40 MHz system clock; all bus and port pins are asynchronous.
package vcf_pkg;

    // System clock and documented pin rates
    localparam int unsigned CLOCK_HZ        = 40_000_000;
    localparam int unsigned ENABLE_CLOCK_HZ = 1_000_000;
    localparam int unsigned CODEC_CLOCK_HZ  = 16_000;
    // Shortest high phase of the enable clock, in system clocks (rounded down, at least 1)
    localparam int unsigned ENABLE_HIGH_CYC =
        (CLOCK_HZ / (2 * ENABLE_CLOCK_HZ)) > 0 ? CLOCK_HZ / (2 * ENABLE_CLOCK_HZ) : 1;
    // System clocks per codec bit
    localparam int unsigned CODEC_BIT_CYC   = CLOCK_HZ / CODEC_CLOCK_HZ;

    // Address decode
    localparam logic [19:0] ADAPTER_ADDR    = 20'he8060;
    localparam logic [2:0]  TOP_GROUP       = 3'h7;
    localparam logic [1:0]  E8000_BITS      = 2'h1;
    localparam logic [2:0]  DECODER_OUT_SEL = 3'h3;

    // Synchroniser depth
    localparam int unsigned SYNC_STAGES     = 3;

    // Control register (register_select low, write)
    localparam int unsigned CTRL_TX_EN_BIT  = 0;
    localparam int unsigned CTRL_IRQ_EN_BIT = 1;
    localparam int unsigned CTRL_CLR_OVR    = 2;
    localparam logic [1:0]  CTRL_RESET      = 2'h0;

    // Status register (register_select low, read)
    localparam int unsigned STAT_ROOM_BIT   = 0;
    localparam int unsigned STAT_EMPTY_BIT  = 1;
    localparam int unsigned STAT_BUSY_BIT   = 2;
    localparam int unsigned STAT_OVR_BIT    = 3;
    localparam int unsigned STAT_TXEN_BIT   = 4;
    localparam int unsigned STAT_IRQEN_BIT  = 5;

    // Shifter
    localparam logic [3:0]  SHIFT_BITS      = 4'h8;
    localparam logic [3:0]  SHIFT_IDLE      = 4'h0;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;

    // Bus and port pins as one carrier
    typedef struct packed {
        logic [19:0] addr;
        logic        io_mem;
        logic        ale;
        logic        phase2;
        logic        enable_clock;
        logic        wr_n;
        logic        rd_n;
        logic        register_select;
        logic [7:0]  data;
        logic        port_b_bit_seven;
        logic        port_b_control_two;
    } vcf_pins_s;

    localparam int unsigned PIN_W = $bits(vcf_pins_s);

endpackage

// >>> vcf_playback.sv
// Playback feed: address decode, serial adapter, byte FIFO, codec drive, volume switch.
// Assumes every bus and interface-adapter pin is asynchronous to clock.
// Summary of operation
// - register_select low picks status/control, high picks data.
// - Write latches only while chip select and write low, enable clock high.
// - Adapter selected at I/O address E8060.
// - Second decoder active only with gate high and both low enables low.
// - First low enable from E8000 decode: A15 high, A16 low.
// - Second low enable asserted while A8 low.
// - Adapter chip select comes from decoder output three.
// - Adapter cleared whenever its reset input is low.
// - Adapter raises service requests on an interrupt output.
// - Data-terminal-ready asserted while adapter holds data to send.
// - Inverted data-terminal-ready drives encode/decode select high for decoding.
// - Bits shift into codec serial input in step with codec clock.
// - Codec clock from port B bit seven, inverted, feeds shift clocks.
// - Codec clock runs at 16 kHz; the host model drives it at 5 MHz (100 ns half period).
// - Volume line drives audio switch true and bias switch inverted.
// - First decoder enabled only for I/O cycles with A19..A17 high.
// - Gate from two flops: ALE trailing edge, then next phase-2 clock.
`timescale 1ns/1ps

module vcf_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             nrst,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign in_ready  = count_q != (AW+1)'(DEPTH);
    assign out_valid = count_q != '0;
    assign out_data  = mem[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // vcf_fifo

module vcf_playback import vcf_pkg::*; #(
    parameter int unsigned FIFO_DEPTH = 16
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // Processor bus
    input  wire logic [19:0] addr,
    input  wire logic        io_mem,
    input  wire logic        ale,
    input  wire logic        phase2,
    input  wire logic        enable_clock,
    input  wire logic        wr_n,
    input  wire logic        rd_n,
    input  wire logic        register_select,
    input  wire logic [7:0]  data_in,
    output logic [7:0]       data_out,
    output logic             data_oe,
    // Decode observation
    output logic             io_decode_gate,
    output logic             codec_port_select_n,
    // Interface adapter lines
    input  wire logic        port_b_bit_seven,
    input  wire logic        port_b_control_two,
    output logic             adapter_irq_n,
    // Codec side
    output logic             receive_shift_clock,
    output logic             transmit_shift_clock,
    output logic             codec_serial_input,
    output logic             data_terminal_ready_n,
    output logic             encode_decode_select,
    // Volume switch
    output logic             audio_pass_en,
    output logic             bias_pass_en
);
    vcf_pins_s        raw;
    vcf_pins_s        pin;
    logic [PIN_W-1:0] s1_q;
    logic [PIN_W-1:0] s2_q;
    logic [PIN_W-1:0] s3_q;
    logic [PIN_W-1:0] flt_q;

    assign raw = '{addr: addr, io_mem: io_mem, ale: ale, phase2: phase2,
                   enable_clock: enable_clock, wr_n: wr_n, rd_n: rd_n,
                   register_select: register_select, data: data_in,
                   port_b_bit_seven: port_b_bit_seven,
                   port_b_control_two: port_b_control_two};
    assign pin = vcf_pins_s'(flt_q);

    // Three-stage input filter, one per pin
    for (genvar i = 0; i < PIN_W; i++) begin : g_sync
        always_ff @(posedge clock) begin
            if (!nrst) begin
                s1_q[i]  <= 1'b0;
                s2_q[i]  <= 1'b0;
                s3_q[i]  <= 1'b0;
                flt_q[i] <= 1'b0;
            end else begin
                s1_q[i] <= raw[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    flt_q[i] <= s3_q[i];
                end
            end
        end
    end

    // Previous filtered levels for edge finding
    logic ale_prev_q;
    logic ph2_prev_q;
    logic cclk_prev_q;
    logic wstb_prev_q;
    logic rstb_prev_q;

    // First-level decode
    logic first_en;
    logic e8000_n;
    assign first_en = !pin.io_mem && (pin.addr[19:17] == TOP_GROUP);
    assign e8000_n  = !(first_en && (pin.addr[16:15] == E8000_BITS));

    // Two-stage decode gate
    logic ale_fall;
    logic ph2_rise;
    logic gate1_q;
    assign ale_fall = ale_prev_q && !pin.ale;
    assign ph2_rise = !ph2_prev_q && pin.phase2;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            gate1_q        <= 1'b0;
            io_decode_gate <= 1'b0;
        end else if (!ale_prev_q && pin.ale) begin
            gate1_q        <= 1'b0;
            io_decode_gate <= 1'b0;
        end else begin
            if (ale_fall && !e8000_n) begin
                gate1_q <= 1'b1;
            end
            if (ph2_rise && gate1_q) begin
                io_decode_gate <= 1'b1;
            end
        end
    end

    // Second-level decoder
    logic enable_low_a;
    logic enable_low_b;
    logic dec_active;
    logic cs_d;
    assign enable_low_a = e8000_n;
    assign enable_low_b = pin.addr[8];
    assign dec_active   = io_decode_gate && !enable_low_a && !enable_low_b;
    assign cs_d         = dec_active && (pin.addr[7:5] == DECODER_OUT_SEL);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            codec_port_select_n <= 1'b1;
        end else begin
            codec_port_select_n <= !cs_d;
        end
    end

    // Bus strobes, one event per enable-clock high phase
    logic wstb;
    logic rstb;
    logic wr_evt;
    logic rd_evt;
    assign wstb   = !codec_port_select_n && !pin.wr_n && pin.enable_clock;
    assign rstb   = !codec_port_select_n && !pin.rd_n && pin.enable_clock;
    assign wr_evt = wstb && !wstb_prev_q;
    assign rd_evt = rstb && !rstb_prev_q;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ale_prev_q  <= 1'b0;
            ph2_prev_q  <= 1'b0;
            cclk_prev_q <= 1'b0;
            wstb_prev_q <= 1'b0;
            rstb_prev_q <= 1'b0;
        end else begin
            ale_prev_q  <= pin.ale;
            ph2_prev_q  <= pin.phase2;
            cclk_prev_q <= pin.port_b_bit_seven;
            wstb_prev_q <= wstb;
            rstb_prev_q <= rstb;
        end
    end

    // Control register and overrun flag
    logic [1:0] ctrl_q;
    logic       overrun_q;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic       data_wr;
    logic       ctrl_wr;
    assign data_wr = wr_evt && pin.register_select;
    assign ctrl_wr = wr_evt && !pin.register_select;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= pin.data[1:0];
        end
    end

    // Set wins over clear
    always_ff @(posedge clock) begin
        if (!nrst) begin
            overrun_q <= 1'b0;
        end else if (data_wr && !fifo_in_ready) begin
            overrun_q <= 1'b1;
        end else if (ctrl_wr && pin.data[CTRL_CLR_OVR]) begin
            overrun_q <= 1'b0;
        end
    end

    // Codec clock: inverted port B bit seven
    logic cclk_inv_rise;
    logic shift_busy;
    logic fifo_pop;
    logic [3:0] bits_q;
    logic [7:0] shreg_q;
    assign cclk_inv_rise = cclk_prev_q && !pin.port_b_bit_seven;
    assign shift_busy    = bits_q != SHIFT_IDLE;
    assign fifo_pop      = cclk_inv_rise && !shift_busy && ctrl_q[CTRL_TX_EN_BIT];

    vcf_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .nrst      (nrst),
        .in_valid  (data_wr),
        .in_ready  (fifo_in_ready),
        .in_data   (pin.data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    always_ff @(posedge clock) begin
        if (!nrst) begin
            receive_shift_clock  <= 1'b1;
            transmit_shift_clock <= 1'b1;
        end else begin
            receive_shift_clock  <= !pin.port_b_bit_seven;
            transmit_shift_clock <= !pin.port_b_bit_seven;
        end
    end

    // Serialiser, LSB first, one bit per codec clock
    always_ff @(posedge clock) begin
        if (!nrst) begin
            bits_q             <= SHIFT_IDLE;
            shreg_q            <= BYTE_RESET;
            codec_serial_input <= 1'b0;
        end else if (cclk_inv_rise) begin
            if (shift_busy) begin
                codec_serial_input <= shreg_q[0];
                shreg_q            <= {1'b0, shreg_q[7:1]};
                bits_q             <= bits_q - 4'h1;
            end else if (fifo_out_valid && fifo_pop) begin
                codec_serial_input <= fifo_out_data[0];
                shreg_q            <= {1'b0, fifo_out_data[7:1]};
                bits_q             <= SHIFT_BITS - 4'h1;
            end
        end
    end

    // Data-terminal-ready and codec mode
    logic holds_data;
    assign holds_data = shift_busy || fifo_out_valid;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            data_terminal_ready_n <= 1'b1;
            encode_decode_select  <= 1'b0;
        end else begin
            data_terminal_ready_n <= !holds_data;
            encode_decode_select  <= holds_data;
        end
    end

    // Status and service request
    logic [7:0] status;
    always_comb begin
        status                 = 8'h00;
        status[STAT_ROOM_BIT]  = fifo_in_ready;
        status[STAT_EMPTY_BIT] = !fifo_out_valid;
        status[STAT_BUSY_BIT]  = shift_busy;
        status[STAT_OVR_BIT]   = overrun_q;
        status[STAT_TXEN_BIT]  = ctrl_q[CTRL_TX_EN_BIT];
        status[STAT_IRQEN_BIT] = ctrl_q[CTRL_IRQ_EN_BIT];
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            adapter_irq_n <= 1'b1;
        end else begin
            adapter_irq_n <= !(ctrl_q[CTRL_IRQ_EN_BIT] && (fifo_in_ready || overrun_q));
        end
    end

    // Read drive
    always_ff @(posedge clock) begin
        if (!nrst) begin
            data_out <= BYTE_RESET;
            data_oe  <= 1'b0;
        end else begin
            data_oe <= rstb;
            if (rd_evt) begin
                data_out <= pin.register_select ? BYTE_RESET : status;
            end
        end
    end

    // Volume switch halves
    always_ff @(posedge clock) begin
        if (!nrst) begin
            audio_pass_en <= 1'b0;
            bias_pass_en  <= 1'b1;
        end else begin
            audio_pass_en <= pin.port_b_control_two;
            bias_pass_en  <= !pin.port_b_control_two;
        end
    end
endmodule // vcf_playback

// >>> vcf_playback_tb_top.sv
// Self-checking bench for the playback feed.
// Assumes the host model drives every bus and port pin.
`timescale 1ns/1ps
module vcf_playback_tb_top;
    import vcf_pkg::*;
    logic       clock, nrst, run_clk, data_oe, io_decode_gate, codec_port_select_n;
    logic       adapter_irq_n, receive_shift_clock, transmit_shift_clock;
    logic       codec_serial_input, data_terminal_ready_n, encode_decode_select;
    logic       audio_pass_en, bias_pass_en;
    logic [2:0] vol_level;
    logic [7:0] data_out, acc, hi, q;
    vcf_pins_s  pins;
    int         errors, checks, cycles, nbit;
    logic [7:0] sent[$];
    logic [7:0] got[$];

    vcf_host_model host (.clock(clock), .pins(pins), .rdata(data_out),
        .vol_level(vol_level), .run_clk(run_clk));

    vcf_playback #(.FIFO_DEPTH(16)) DUT (
        .clock(clock), .nrst(nrst), .addr(pins.addr), .io_mem(pins.io_mem),
        .ale(pins.ale), .phase2(pins.phase2), .enable_clock(pins.enable_clock),
        .wr_n(pins.wr_n), .rd_n(pins.rd_n), .register_select(pins.register_select),
        .data_in(pins.data), .data_out(data_out), .data_oe(data_oe),
        .io_decode_gate(io_decode_gate), .codec_port_select_n(codec_port_select_n),
        .port_b_bit_seven(pins.port_b_bit_seven),
        .port_b_control_two(pins.port_b_control_two), .adapter_irq_n(adapter_irq_n),
        .receive_shift_clock(receive_shift_clock),
        .transmit_shift_clock(transmit_shift_clock),
        .codec_serial_input(codec_serial_input),
        .data_terminal_ready_n(data_terminal_ready_n),
        .encode_decode_select(encode_decode_select),
        .audio_pass_en(audio_pass_en), .bias_pass_en(bias_pass_en));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic close_out();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] stat(input logic room, empty, ovr, txen, irqen);
        stat = 8'h00;
        stat[STAT_ROOM_BIT] = room;
        stat[STAT_EMPTY_BIT] = empty;
        stat[STAT_OVR_BIT] = ovr;
        stat[STAT_TXEN_BIT] = txen;
        stat[STAT_IRQEN_BIT] = irqen;
    endfunction

    task automatic wr(input logic [19:0] a, input logic io, input logic sel, input logic [7:0] d);
        logic [7:0] r;
        host.cycle(a, io, sel, 1'b1, d, r);
    endtask

    task automatic rd_chk(input logic sel, input logic [7:0] e);
        logic [7:0] r;
        host.cycle(ADAPTER_ADDR, 1'b0, sel, 1'b0, 8'h00, r);
        check(r, e);
    endtask

    task automatic do_reset();
        nrst = 1'b0;
        repeat (8) @(posedge clock);
        #1;
        nrst = 1'b1;
    endtask

    // Serial capture at the middle of each bit, LSB first
    always @(negedge transmit_shift_clock) begin
        // Last bit of a frame still counts after ready has dropped
        if (nrst && (!data_terminal_ready_n || nbit != 0)) begin
            acc = {codec_serial_input, acc[7:1]};
            nbit++;
            if (nbit == 8) begin
                got.push_back(acc);
                nbit = 0;
            end
        end
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end

    logic [19:0] bad_addr[5] = '{20'he8160, 20'he8040, 20'he0060, 20'h68060, 20'he8060};

    initial begin
        nrst = 1'b0;
        run_clk = 1'b0;
        vol_level = 3'h7;
        void'($urandom(32'hb0e2c05e));
        do_reset();
        check({data_oe, codec_port_select_n, adapter_irq_n, data_terminal_ready_n,
               encode_decode_select, transmit_shift_clock, audio_pass_en, bias_pass_en},
              8'h75);
        wr(ADAPTER_ADDR, 1'b0, 1'b0, 8'h00);
        for (int i = 0; i < 5; i++)
            wr(bad_addr[i], i == 4, 1'b1, 8'(32'($urandom)));
        rd_chk(1'b0, stat(1, 1, 0, 0, 0));
        for (int i = 0; i < 17; i++) begin
            q = 8'($urandom);
            if (i < 16)
                sent.push_back(q);
            wr(ADAPTER_ADDR, 1'b0, 1'b1, q);
        end
        rd_chk(1'b0, stat(0, 0, 1, 0, 0));
        rd_chk(1'b1, 8'h00);
        wr(ADAPTER_ADDR, 1'b0, 1'b0, 8'h07);
        rd_chk(1'b0, stat(0, 0, 0, 1, 1));
        check({5'h00, adapter_irq_n, data_terminal_ready_n, encode_decode_select},
              8'h05);
        run_clk = 1'b1;
        for (int i = 0; i < 4000 && got.size() < 16; i++)
            @(posedge clock);
        run_clk = 1'b0;
        check(8'(got.size()), 8'h10);
        for (int i = 0; i < 16 && i < got.size(); i++)
            check(got[i], sent[i]);
        for (int i = 0; i < 200 && data_terminal_ready_n !== 1'b1; i++)
            @(posedge clock);
        #1;
        check({5'h00, adapter_irq_n, data_terminal_ready_n, encode_decode_select},
              8'h02);
        for (int lv = 0; lv < 8; lv++) begin
            vol_level = 3'(lv);
            hi = 8'h00;
            repeat (80) @(posedge clock);
            repeat (64) begin
                @(posedge clock);
                #1;
                hi = hi + {7'h00, audio_pass_en};
            end
            check(hi, 8'((lv + 1) * 8));
        end
        #1;
        do_reset();
        rd_chk(1'b0, stat(1, 1, 0, 0, 0));
        close_out();
    end
endmodule // vcf_playback_tb_top
